// File: hw/sar_ctl_pkg.sv
// Shared constants and types for the successive-approximation conversion control.
// Assumes a 16-bit word-addressed register port and a single system clock.
package sar_ctl_pkg;

  // Register word addresses.
  localparam logic [15:0] CTRL_ADDR = 16'h7012;
  localparam logic [15:0] DATA_ADDR = 16'h7014;

  // Control word field positions and reset value.
  localparam int          START_BIT     = 15;
  localparam int          INPUT_CHANNEL_SELECT_LSB     = 12;
  localparam int          EXT_BIT       = 11;
  localparam int          ONE_SHOT_BIT  = 10;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;

  // Result word field positions.
  localparam int          BUSY_BIT      = 15;
  localparam int          CHAN_LSB      = 12;

  // Channel codes and switch patterns.
  localparam int          NUM_INPUTS    = 6;
  localparam logic [2:0]  LAST_CHANNEL  = 3'h5;
  localparam logic [5:0]  SWITCH_NONE   = 6'h00;

  // Converter timing, counted in converter clock ticks, then the first trial code and its top bit.
  localparam logic [5:0]  BUSY_DELAY    = 6'h03;
  localparam logic [5:0]  CONV_CYCLES   = 6'h20;
  localparam logic [5:0]  CONV_LAST     = 6'(CONV_CYCLES - 6'h01);
  localparam logic [5:0]  SAMP_NORM     = 6'h02;
  localparam logic [5:0]  SAMP_EXT      = 6'h0c;
  localparam logic [1:0]  SLOT_NORM     = 2'h3;
  localparam logic [1:0]  SLOT_EXT      = 2'h2;
  localparam logic [9:0]  TRIAL_INIT    = 10'h200;
  localparam logic [3:0]  TOP_BIT       = 4'h9;

  // Control word, packed in its register bit order.
  typedef struct packed {
    logic       conversion_start_bit;
    logic [2:0] input_channel_select;
    logic       extended_sampling_mode;
    logic       one_shot_mode;
    logic [9:0] spare;
  } ctrl_s;

  // One register access from the processor side.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } conv_state_e;

endpackage

// File: hw/conv_tick_divider.sv
// Divides the system clock into a one-cycle converter tick.
// Assumes the divisor is static while conversions run.
`timescale 1ns/10ps
`default_nettype none
module conv_tick_divider
  import sar_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Divisor, tick rate is ref_clk / (div + 1)
  input  wire logic [14:0] div,
  // Converter tick
  output logic             tick
);

  typedef struct packed {
    logic [14:0] cnt;
    logic        tick;
  } div_state_s;

  div_state_s q;
  div_state_s d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt >= div) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = 15'(q.cnt + 15'h0001);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule
`default_nettype wire

// File: hw/sar_conversion_control.sv
// Conversion control for a 10-bit successive-approximation converter.
// Assumes a synchronous register port on ref_clk and an asynchronous comparator output.
`timescale 1ns/10ps
`default_nettype none
module sar_conversion_control
  import sar_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Register port
  input  wire reg_req_s   req,
  output logic [15:0]     reg_rdata,
  // Converter clock divisor
  input  wire logic [14:0] sar_clk_div,
  // Analog side
  output logic [5:0]      switch_en,
  output logic            sample_en,
  output logic            cmp_strobe,
  output logic [9:0]      dac_code,
  input  wire logic       comp_in
);

  typedef struct packed {
    conv_state_e fsm;
    ctrl_s       ctrl;
    logic        armed;
    logic        busy;
    logic [2:0]  res_chan;
    logic [9:0]  res_data;
    logic [9:0]  trial;
    logic [3:0]  bit_idx;
    logic [1:0]  slot;
    logic [5:0]  cnt;
    logic        conv_ext;
    logic        conv_one;
    logic        comp_meta;
    logic        comp_sync;
    logic [5:0]  switch_q;
    logic [15:0] rdata;
  } state_s;

  state_s q;
  state_s d;
  logic   tick;
  logic   in_bits;
  logic   decide;

  function automatic logic [5:0] switch_decode(input logic [2:0] chan);
    logic [5:0] pat;
    pat = SWITCH_NONE;
    if (chan <= LAST_CHANNEL) begin
      pat = 6'(6'h01 << chan);
    end
    return pat;
  endfunction

  function automatic logic [5:0] samp_len(input logic ext);
    return ext ? SAMP_EXT : SAMP_NORM;
  endfunction

  function automatic logic [1:0] slot_len(input logic ext);
    return ext ? SLOT_EXT : SLOT_NORM;
  endfunction

  conv_tick_divider u_div (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .div     (sar_clk_div),
    .tick    (tick)
  );

  // Extended timing trades settle slots for sample slots so the total stays fixed.
  assign in_bits = (q.fsm == ST_CONV) && (q.cnt >= samp_len(q.conv_ext));
  assign decide  = in_bits && (q.slot == 2'(slot_len(q.conv_ext) - 2'h1));

  always_comb begin
    d           = q;
    d.comp_meta = comp_in;
    d.comp_sync = q.comp_meta;
    d.switch_q  = switch_decode(q.ctrl.input_channel_select);
    if (!q.ctrl.conversion_start_bit) begin
      d.armed = 1'b1;
    end
    case (q.fsm)
      ST_IDLE: begin
        if (q.ctrl.conversion_start_bit && q.armed) begin
          d.fsm = ST_WAIT;
          d.cnt = '0;
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (q.cnt == 6'(BUSY_DELAY - 6'h01)) begin
            d.fsm      = ST_CONV;
            d.busy     = 1'b1;
            d.cnt      = '0;
            d.slot     = '0;
            d.trial    = TRIAL_INIT;
            d.bit_idx  = TOP_BIT;
            d.conv_ext = q.ctrl.extended_sampling_mode;
            d.conv_one = q.ctrl.one_shot_mode;
          end else begin
            d.cnt = 6'(q.cnt + 6'h01);
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          d.cnt = 6'(q.cnt + 6'h01);
          if (in_bits) begin
            if (decide) begin
              d.slot = '0;
              if (!q.comp_sync) begin
                d.trial[q.bit_idx] = 1'b0;
              end
              if (q.bit_idx != 4'h0) begin
                d.trial[4'(q.bit_idx - 4'h1)] = 1'b1;
                d.bit_idx = 4'(q.bit_idx - 4'h1);
              end
            end else begin
              d.slot = 2'(q.slot + 2'h1);
            end
          end
          if (q.cnt == CONV_LAST) begin
            d.busy     = 1'b0;
            d.res_data = d.trial;
            d.res_chan = q.ctrl.input_channel_select;
            if (q.conv_one) begin
              d.ctrl.conversion_start_bit = 1'b0;
              d.armed = 1'b0;
              d.fsm   = ST_IDLE;
            end else if (q.ctrl.conversion_start_bit) begin
              d.fsm = ST_WAIT;
              d.cnt = '0;
            end else begin
              d.fsm = ST_IDLE;
            end
          end
        end
      end
      default: begin
        d.fsm = ST_IDLE;
      end
    endcase
    // A software write lands last, so a start written in the completion cycle is kept.
    if (req.wr && (req.addr == CTRL_ADDR)) begin
      d.ctrl = ctrl_s'(req.wdata);
    end
    if (req.rd) begin
      case (req.addr)
        CTRL_ADDR: d.rdata = 16'(q.ctrl);
        DATA_ADDR: d.rdata = {q.busy, q.res_chan, 2'h0, q.res_data};
        default:   d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q       <= '0;
      q.fsm   <= ST_IDLE;
      q.ctrl  <= ctrl_s'(CTRL_RESET);
      q.armed <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata  = q.rdata;
  assign switch_en  = q.switch_q;
  assign dac_code   = q.trial;
  assign sample_en  = (q.fsm == ST_CONV) && !in_bits;
  assign cmp_strobe = decide && tick;

  // Checks on the sequencing.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_switch_select: assert property (
    (q.ctrl.input_channel_select inside {[3'h1:3'h5]}) |=>
      switch_en == 6'(6'h01 << $past(q.ctrl.input_channel_select)))
    else $error("selected input switch not closed alone");

  chk_switch_zero: assert property (
    (q.ctrl.input_channel_select == 3'h0) |=> switch_en == 6'h01)
    else $error("code zero does not route input zero");

  chk_switch_open: assert property (
    (q.ctrl.input_channel_select >= 3'h6) |=> switch_en == 6'h00)
    else $error("reserved code left a switch closed");

  chk_ext_sampling: assert property (
    (q.fsm == ST_CONV && q.conv_ext && q.cnt == 6'd11) |-> sample_en)
    else $error("extended sampling window too short");

  chk_norm_sampling: assert property (
    (q.fsm == ST_CONV && !q.conv_ext && q.cnt == 6'd2) |-> !sample_en && in_bits)
    else $error("normal sampling window wrong length");

  chk_conv_length: assert property (
    $fell(q.busy) |-> $past(q.cnt) == 6'd31 && $past(tick))
    else $error("conversion did not last 32 ticks");

  chk_busy_delay: assert property (
    $rose(q.busy) |-> $past(q.fsm) == ST_WAIT && $past(q.cnt) == 6'd2 && $past(tick))
    else $error("busy not set three ticks after start");

  chk_start_launch: assert property (
    (q.fsm == ST_IDLE && q.armed && q.ctrl.conversion_start_bit) |=> q.fsm == ST_WAIT)
    else $error("start bit did not launch a conversion");

  chk_one_shot_end: assert property (
    ($fell(q.busy) && $past(q.conv_one) && !$past(req.wr)) |->
      !q.ctrl.conversion_start_bit && q.fsm == ST_IDLE)
    else $error("one-shot completion left start set");

  chk_no_relaunch: assert property (
    (q.fsm == ST_IDLE && !q.armed) |=> q.fsm == ST_IDLE)
    else $error("held start relaunched a one-shot conversion");

  chk_continuous: assert property (
    ($fell(q.busy) && !$past(q.conv_one) && $past(q.ctrl.conversion_start_bit)) |-> q.fsm == ST_WAIT)
    else $error("continuous mode stopped while start set");

  chk_capture: assert property (
    $fell(q.busy) |-> q.res_chan == $past(q.ctrl.input_channel_select) &&
      q.res_data[9:1] == $past(q.trial[9:1]) &&
      q.res_data[0] == ($past(q.trial[0]) && $past(q.comp_sync)))
    else $error("channel and result not captured together");

  chk_busy_read: assert property (
    (req.rd && req.addr == DATA_ADDR) |=> reg_rdata[BUSY_BIT] == $past(q.busy))
    else $error("data register busy bit wrong");

  cov_one_shot: cover property ($fell(q.busy) && $past(q.conv_one));
  cov_continuous: cover property ($fell(q.busy) ##1 (q.fsm == ST_WAIT) [*2] ##[1:300] $rose(q.busy));
  cov_extended: cover property ($fell(q.busy) && $past(q.conv_ext));

endmodule
`default_nettype wire

// File: verification/sar_analog_model.sv
// Behavioural analog side: fixed input levels behind the switches and an ideal comparator.
// Assumes one-hot switch closes and a trial code that is steady between decisions.
`timescale 1ns/10ps
`default_nettype none
module sar_analog_model #(
  parameter logic [59:0] LEVELS = 60'h0
) (
  // Clock
  input  wire logic       ref_clk,
  // Converter side
  input  wire logic [5:0] switch_en,
  input  wire logic [9:0] dac_code,
  output logic            comp_in
);
  logic float_q = 1'b0;
  // With no switch closed the input floats, so the comparator wanders every cycle.
  always @(posedge ref_clk) float_q <= ~float_q;
  always_comb begin
    comp_in = float_q;
    for (int n = 0; n < 6; n++) begin
      if (switch_en == 6'(1 << n)) begin
        comp_in = (LEVELS[n*10 +: 10] >= dac_code);
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the conversion control, driving the register port.
// Assumes the converter tick runs at ref_clk/4 and the analog model's fixed levels.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sar_ctl_pkg::*;
  localparam logic [59:0] LEVELS = {10'h0f0, 10'h200, 10'h3fe, 10'h001, 10'h2aa, 10'h155};
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  reg_req_s    req = '0;
  logic [15:0] reg_rdata;
  logic [15:0] rd_q;
  logic [5:0]  switch_en;
  logic        sample_en;
  logic        cmp_strobe;
  logic [9:0]  dac_code;
  logic        comp_in;
  logic [2:0]  ch;
  int          num_errors = 0;
  int          num_checks = 0;
  int          lat, slen, nstr, span, rises, k;
  // Extended timing is kept to the last two rows, as software would use it only where it helps.
  logic [15:0] row_ctrl [10] = '{16'h8400, 16'h9400, 16'ha400, 16'hb400, 16'hc400,
                                 16'hd400, 16'he400, 16'hf400, 16'h8c00, 16'hdc00};
  logic [5:0]  row_sw [10] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00, 6'h00, 6'h01, 6'h20};
  int          row_slen [10] = '{7, 7, 7, 7, 7, 7, 7, 7, 47, 47};

  always #5 ref_clk = ~ref_clk;

  sar_conversion_control dut (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .reg_rdata(reg_rdata),
    .sar_clk_div(15'h0003), .switch_en(switch_en), .sample_en(sample_en), .cmp_strobe(cmp_strobe),
    .dac_code(dac_code), .comp_in(comp_in));
  sar_analog_model #(.LEVELS(LEVELS)) model (.ref_clk(ref_clk), .switch_en(switch_en),
    .dac_code(dac_code), .comp_in(comp_in));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    step(1);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    req.rd = 1'b1;
    req.addr = a;
    step(1);
    req.rd = 1'b0;
    rd_q = reg_rdata;
  endtask
  task automatic count_rises(input int n);
    logic p;
    rises = 0;
    repeat (n) begin
      p = sample_en;
      step(1);
      if (p === 1'b0 && sample_en === 1'b1) rises++;
    end
  endtask
  // Measures launch latency, sampling length, decision count and span of one conversion.
  task automatic convert(input logic [15:0] w);
    wr(CTRL_ADDR, w);
    lat = 1;
    slen = 0;
    nstr = 0;
    span = 0;
    while (sample_en !== 1'b1 && lat < 40) begin
      step(1);
      lat++;
    end
    while (nstr < 10 && span < 400) begin
      step(1);
      span++;
      slen += int'(sample_en === 1'b1);
      nstr += int'(cmp_strobe === 1'b1);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    conclude();
  end

  initial begin
    step(10);
    rst_b = 1'b1;
    rd(CTRL_ADDR);
    check(rd_q, CTRL_RESET);
    step(1);
    rd(DATA_ADDR);
    check(rd_q, 16'h0000);
    check({10'h000, switch_en}, 16'h0001);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      ch = row_ctrl[i][14:12];
      convert(row_ctrl[i]);
      check({10'h000, switch_en}, {10'h000, row_sw[i]});
      check(16'(lat >= 11 && lat <= 14), 16'h0001);
      check(16'(slen), 16'(row_slen[i]));
      check(16'(nstr), 16'h000a);
      check(16'(span), 16'h007f);
      k = 0;
      do begin
        step(1);
        rd(DATA_ADDR);
        k++;
      end while (rd_q[15] !== 1'b0 && k < 20);
      if (ch <= LAST_CHANNEL) check(rd_q, {1'b0, ch, 2'b00, LEVELS[ch*10 +: 10]});
      else check(rd_q & 16'hf000, {1'b0, ch, 12'h000});
      step(1);
      rd(CTRL_ADDR);
      check(rd_q, row_ctrl[i] & 16'h7fff);
      step(1);
      $display("row %0d done", i);
    end
    wr(CTRL_ADDR, 16'h9000);
    count_rises(400);
    check(16'(rises), 16'h0003);
    wr(CTRL_ADDR, 16'h1000);
    count_rises(400);
    check(16'(rises), 16'h0000);
    rd(DATA_ADDR);
    check(rd_q, {4'h1, 2'b00, LEVELS[19:10]});
    $display("continuous test done");
    step(1);
    wr(16'h7016, 16'hffff);
    rd(16'h7016);
    check(rd_q, 16'h0000);
    step(1);
    wr(DATA_ADDR, 16'h0000);
    rd(DATA_ADDR);
    check(rd_q, {4'h1, 2'b00, LEVELS[19:10]});
    step(1);
    wr(CTRL_ADDR, 16'h03ff);
    rd(CTRL_ADDR);
    check(rd_q, 16'h03ff);
    count_rises(100);
    check(16'(rises), 16'h0000);
    $display("refusal test done");
    // A reset in mid-conversion must drop every register back to its default.
    wr(CTRL_ADDR, 16'h9400);
    step(30);
    rd(DATA_ADDR);
    check(rd_q, {4'h9, 2'b00, LEVELS[19:10]});
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    rd(CTRL_ADDR);
    check(rd_q, CTRL_RESET);
    step(1);
    rd(DATA_ADDR);
    check(rd_q, 16'h0000);
    check({10'h000, switch_en}, 16'h0001);
    count_rises(60);
    check(16'(rises), 16'h0000);
    $display("mid-run reset test done");
    conclude();
  end
endmodule
`default_nettype wire
